// *** drs_pkg.sv ***
// Purpose: Shared constants and types of the drive status relay and fault lock block.
// Assumes: One 10 MHz clock and an AXI4-Lite register port with 32-bit data.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package drs_pkg;

  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_SEL     = 8'h04;
  localparam logic [7:0]  OFF_LIMIT   = 8'h08;
  localparam logic [7:0]  OFF_STATUS  = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_ST  = 8'h10;
  localparam logic [7:0]  OFF_IRQ_MSK = 8'h14;

  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_ACK_BIT  = 8;
  localparam logic [1:0]  MODE_RESET    = 2'h0;

  localparam int          NUM_RELAYS  = 4;
  localparam int          SEL_W       = 4;
  localparam int          FUNC_N      = 16;
  localparam logic [15:0] SEL_RESET   = 16'h719A;
  localparam logic [15:0] LIMIT_RESET = 16'h0100;
  localparam int          SPEED_W     = 16;

  localparam int          ST_LOCKED_BIT = 0;
  localparam int          ST_CNT_LSB    = 1;
  localparam int          ST_EVAC_BIT   = 3;
  localparam int          ST_FREL_BIT   = 4;
  localparam int          ST_OVSP_BIT   = 5;
  localparam int          ST_RELAY_LSB  = 8;

  localparam int          IRQ_W         = 4;
  localparam int          IRQ_FAULT     = 0;
  localparam int          IRQ_LOCK      = 1;
  localparam int          IRQ_EVAC      = 2;
  localparam int          IRQ_OVERSPEED = 3;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  localparam int          CLK_HZ       = 10_000_000;
  localparam int          DROP_TIME_MS = 2000;
  localparam int          DROP_CYCLES  = DROP_TIME_MS * (CLK_HZ / 1000);
  localparam int          DROP_CNT_W   = 25;

  typedef enum logic [1:0] {
    MODE_FIX_2S = 2'h0,
    MODE_LOCK_3 = 2'h1,
    MODE_LOCK_2 = 2'h2,
    MODE_LOCK_1 = 2'h3
  } drs_mode_t;

  typedef enum logic [3:0] {
    FN_OFF     = 4'h0,
    FN_STO_BLK = 4'h1,
    FN_STO_CLR = 4'h2,
    FN_BRAKE   = 4'h3,
    FN_FB_EN   = 4'h4,
    FN_OVSPEED = 4'h5,
    FN_MSHORT  = 4'h6,
    FN_EVAC    = 4'h7,
    FN_REGEN   = 4'h8,
    FN_READY   = 4'h9,
    FN_FAULT   = 4'hA
  } drs_func_t;

endpackage

// *** drs_hold_timer.sv ***
// Purpose: Retriggerable hold timer, busy for a fixed number of cycles after a start.
// Assumes: i_start is a one-cycle pulse; CYCLES is at least 2.
// Notes:   A start while busy reloads the full count.
module drs_hold_timer #(
  parameter int CNT_W  = 25,
  parameter int CYCLES = 20_000_000
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_start,
  output logic      o_busy
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (i_start)
    begin
      cnt_next = CNT_W'(CYCLES - 1);
    end
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_reg <= '0;
      o_busy  <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      o_busy  <= (cnt_next != '0);
    end
  end

endmodule

// *** drs_relay_mux.sv ***
// Purpose: Per-relay function selector.
// Assumes: Each relay has a SEL_W-bit code indexing the function vector.
// Notes:   Purely combinational; the caller registers the result.
module drs_relay_mux #(
  parameter int N     = 4,
  parameter int SEL_W = 4
) (
  input  wire logic [(1<<SEL_W)-1:0] i_func,
  input  wire logic [N*SEL_W-1:0]    i_sel,
  output logic      [N-1:0]          o_relay
);

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_relay
      assign o_relay[gi] = i_func[i_sel[gi*SEL_W +: SEL_W]];
    end
  endgenerate

endmodule

// *** drs_status_relays.sv ***
// Purpose: Status relay outputs and fault lockout of a lift drive.
// Assumes: All inputs synchronous to i_clk; fault and travel-done inputs are pulses.
// Notes:   Registers over AXI4-Lite; one level interrupt from sticky status bits.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
module drs_status_relays #(
  parameter int DROP_CYCLES = drs_pkg::DROP_CYCLES
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  input  wire logic                       i_awvalid,
  output logic                            o_awready,
  input  wire logic [drs_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                       i_wvalid,
  output logic                            o_wready,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  output logic                            o_bvalid,
  input  wire logic                       i_bready,
  output logic      [1:0]                 o_bresp,
  input  wire logic                       i_arvalid,
  output logic                            o_arready,
  input  wire logic [drs_pkg::ADDR_W-1:0] i_araddr,
  output logic                            o_rvalid,
  input  wire logic                       i_rready,
  output logic      [31:0]                o_rdata,
  output logic      [1:0]                 o_rresp,
  input  wire logic                       i_sto_blocked,
  input  wire logic [3:0]                 i_brake_open,
  input  wire logic                       i_travel_active,
  input  wire logic                       i_ctrl_enable,
  input  wire logic                       i_speed_sel,
  input  wire logic                       i_dir_sel,
  input  wire logic [drs_pkg::SPEED_W-1:0] i_cabin_speed,
  input  wire logic                       i_motor_short_req,
  input  wire logic                       i_battery_evac_active,
  input  wire logic                       i_standstill,
  input  wire logic                       i_line_ok,
  input  wire logic                       i_regen,
  input  wire logic                       i_ready_cond,
  input  wire logic                       i_fault,
  input  wire logic                       i_travel_ok,
  input  wire logic                       i_ack_key,
  output logic      [drs_pkg::NUM_RELAYS-1:0] o_relay,
  output logic                            o_lock_msg,
  output logic                            o_evac_restart,
  output logic                            o_irq
);

  typedef enum logic [1:0] {EV_IDLE, EV_DISC, EV_WAIT} drs_evac_t;
  typedef enum logic [2:0] {
    R_CTRL, R_SEL, R_LIMIT, R_STATUS, R_IRQ_ST, R_IRQ_MSK, R_NONE
  } drs_reg_t;

  typedef struct packed {
    logic                                 awready;
    logic                                 wready;
    logic                                 bvalid;
    logic [1:0]                           bresp;
    logic                                 aw_have;
    logic                                 w_have;
    logic [drs_pkg::ADDR_W-1:0]           aw_addr;
    logic [31:0]                          wdata;
    logic [3:0]                           wstrb;
    logic                                 arready;
    logic                                 rvalid;
    logic [1:0]                           rresp;
    logic [31:0]                          rdata;
    drs_pkg::drs_mode_t                   mode;
    logic [15:0]                          sel;
    logic [drs_pkg::SPEED_W-1:0]          limit;
    logic [drs_pkg::IRQ_W-1:0]            irq_stat;
    logic [drs_pkg::IRQ_W-1:0]            irq_mask;
    logic                                 irq;
    logic [1:0]                           fault_cnt;
    logic                                 locked;
    logic                                 fault_relay;
    logic                                 ovsp;
    logic [drs_pkg::NUM_RELAYS-1:0]       relay;
    drs_evac_t                            evac;
    logic                                 evac_restart;
  } drs_state_t;

  function automatic drs_reg_t reg_sel(input logic [drs_pkg::ADDR_W-1:0] a);
    logic [drs_pkg::ADDR_W-1:0] w;
    w = {a[drs_pkg::ADDR_W-1:2], 2'h0};
    unique case (w)
      drs_pkg::OFF_CTRL:    reg_sel = R_CTRL;
      drs_pkg::OFF_SEL:     reg_sel = R_SEL;
      drs_pkg::OFF_LIMIT:   reg_sel = R_LIMIT;
      drs_pkg::OFF_STATUS:  reg_sel = R_STATUS;
      drs_pkg::OFF_IRQ_ST:  reg_sel = R_IRQ_ST;
      drs_pkg::OFF_IRQ_MSK: reg_sel = R_IRQ_MSK;
      default:              reg_sel = R_NONE;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input drs_state_t s, input drs_reg_t r);
    rd_word = 32'h0000_0000;
    unique case (r)
      R_CTRL:    rd_word[drs_pkg::CTRL_MODE_LSB +: 2] = s.mode;
      R_SEL:     rd_word[15:0] = s.sel;
      R_LIMIT:   rd_word[drs_pkg::SPEED_W-1:0] = s.limit;
      R_STATUS:
      begin
        rd_word[drs_pkg::ST_LOCKED_BIT] = s.locked;
        rd_word[drs_pkg::ST_CNT_LSB +: 2] = s.fault_cnt;
        rd_word[drs_pkg::ST_EVAC_BIT] = (s.evac != EV_IDLE);
        rd_word[drs_pkg::ST_FREL_BIT] = s.fault_relay;
        rd_word[drs_pkg::ST_OVSP_BIT] = s.ovsp;
        rd_word[drs_pkg::ST_RELAY_LSB +: drs_pkg::NUM_RELAYS] = s.relay;
      end
      R_IRQ_ST:  rd_word[drs_pkg::IRQ_W-1:0] = s.irq_stat;
      R_IRQ_MSK: rd_word[drs_pkg::IRQ_W-1:0] = s.irq_mask;
      R_NONE:    rd_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [31:0] byte_mask(input logic [3:0] strb);
    for (int b = 0; b < 4; b++)
    begin
      byte_mask[b*8 +: 8] = {8{strb[b]}};
    end
  endfunction

  function automatic logic [1:0] lock_thr(input drs_pkg::drs_mode_t m);
    unique case (m)
      drs_pkg::MODE_LOCK_3: lock_thr = 2'h3;
      drs_pkg::MODE_LOCK_2: lock_thr = 2'h2;
      drs_pkg::MODE_LOCK_1: lock_thr = 2'h1;
      drs_pkg::MODE_FIX_2S: lock_thr = 2'h0;
    endcase
  endfunction

  drs_state_t                     q;
  drs_state_t                     n;
  logic [drs_pkg::FUNC_N-1:0]     func;
  logic [drs_pkg::NUM_RELAYS-1:0] relay_sel;
  logic                           drop_start;
  logic                           drop_busy;
  logic [31:0]                    bmask;
  logic [31:0]                    wword;
  logic [drs_pkg::IRQ_W-1:0]      irq_clr;
  logic [drs_pkg::IRQ_W-1:0]      ev;
  logic                           ack;
  logic [1:0]                     cnt_inc;

  assign func[drs_pkg::FN_OFF]     = 1'b0;
  assign func[drs_pkg::FN_STO_BLK] = i_sto_blocked;
  assign func[drs_pkg::FN_STO_CLR] = ~i_sto_blocked;
  assign func[drs_pkg::FN_BRAKE]   = (&i_brake_open) & i_travel_active;
  assign func[drs_pkg::FN_FB_EN]   = i_ctrl_enable & i_speed_sel & i_dir_sel;
  assign func[drs_pkg::FN_OVSPEED] = q.ovsp;
  assign func[drs_pkg::FN_MSHORT]  = i_motor_short_req;
  assign func[drs_pkg::FN_EVAC]    = (q.evac != EV_IDLE);
  assign func[drs_pkg::FN_REGEN]   = i_regen;
  assign func[drs_pkg::FN_READY]   = i_ready_cond & ~q.locked;
  assign func[drs_pkg::FN_FAULT]   = q.fault_relay;
  assign func[15:11]               = 5'h00;

  assign drop_start = i_fault && (q.mode == drs_pkg::MODE_FIX_2S);

  drs_relay_mux #(
    .N     (drs_pkg::NUM_RELAYS),
    .SEL_W (drs_pkg::SEL_W)
  ) u_mux (
    .i_func  (func),
    .i_sel   (q.sel),
    .o_relay (relay_sel)
  );

  drs_hold_timer #(
    .CNT_W  (drs_pkg::DROP_CNT_W),
    .CYCLES (DROP_CYCLES)
  ) u_drop (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_start (drop_start),
    .o_busy  (drop_busy)
  );

  always_comb
  begin
    n       = q;
    irq_clr = '0;
    ev      = '0;
    ack     = i_ack_key;
    bmask   = byte_mask(q.wstrb);
    wword   = (rd_word(q, reg_sel(q.aw_addr)) & ~bmask) | (q.wdata & bmask);
    cnt_inc = q.fault_cnt + 2'h1;
    n.evac_restart = 1'b0;
    if (i_awvalid && q.awready)
    begin
      n.aw_have = 1'b1;
      n.aw_addr = i_awaddr;
    end
    if (i_wvalid && q.wready)
    begin
      n.w_have = 1'b1;
      n.wdata  = i_wdata;
      n.wstrb  = i_wstrb;
    end
    if (q.bvalid && i_bready)
    begin
      n.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = drs_pkg::RESP_OKAY;
      unique case (reg_sel(q.aw_addr))
        R_CTRL:
        begin
          n.mode = drs_pkg::drs_mode_t'(wword[drs_pkg::CTRL_MODE_LSB +: 2]);
          ack = i_ack_key | (q.wdata[drs_pkg::CTRL_ACK_BIT] & q.wstrb[1]);
        end
        R_SEL:     n.sel = wword[15:0];
        R_LIMIT:   n.limit = wword[drs_pkg::SPEED_W-1:0];
        R_STATUS:  n.bresp = drs_pkg::RESP_OKAY;
        R_IRQ_ST:  irq_clr = q.wdata[drs_pkg::IRQ_W-1:0] & bmask[drs_pkg::IRQ_W-1:0];
        R_IRQ_MSK: n.irq_mask = wword[drs_pkg::IRQ_W-1:0];
        R_NONE:    n.bresp = drs_pkg::RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready  = !n.w_have && !n.bvalid;
    if (q.rvalid && i_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (i_arvalid && q.arready)
    begin
      n.rvalid = 1'b1;
      n.rdata  = rd_word(q, reg_sel(i_araddr));
      n.rresp  = (reg_sel(i_araddr) == R_NONE) ? drs_pkg::RESP_SLVERR : drs_pkg::RESP_OKAY;
    end
    n.arready = !n.rvalid;
    if (q.mode == drs_pkg::MODE_FIX_2S)
    begin
      n.locked      = 1'b0;
      n.fault_cnt   = 2'h0;
      n.fault_relay = !(drop_busy || drop_start);
    end
    else
    begin
      if (q.locked && ack)
      begin
        n.locked    = 1'b0;
        n.fault_cnt = 2'h0;
      end
      else if (i_fault && !q.locked)
      begin
        n.fault_cnt = cnt_inc;
        if (cnt_inc >= lock_thr(q.mode))
        begin
          n.locked = 1'b1;
        end
      end
      else if (i_travel_ok && !q.locked)
      begin
        n.fault_cnt = 2'h0;
      end
      n.fault_relay = !n.locked;
    end
    if (i_cabin_speed > q.limit)
    begin
      n.ovsp = 1'b0;
    end
    else if (i_cabin_speed < q.limit)
    begin
      n.ovsp = 1'b1;
    end
    unique case (q.evac)
      EV_IDLE:
      begin
        if (i_battery_evac_active)
        begin
          n.evac = EV_DISC;
        end
      end
      EV_DISC:
      begin
        if (!i_battery_evac_active)
        begin
          n.evac = EV_IDLE;
        end
        else if (i_standstill)
        begin
          n.evac         = EV_WAIT;
          n.evac_restart = 1'b1;
        end
      end
      EV_WAIT:
      begin
        if (i_line_ok)
        begin
          n.evac = EV_IDLE;
        end
      end
      default: n.evac = EV_IDLE;
    endcase
    n.relay = relay_sel;
    ev[drs_pkg::IRQ_FAULT]     = i_fault;
    ev[drs_pkg::IRQ_LOCK]      = n.locked && !q.locked;
    ev[drs_pkg::IRQ_EVAC]      = (q.evac == EV_IDLE) && (n.evac == EV_DISC);
    ev[drs_pkg::IRQ_OVERSPEED] = q.ovsp && !n.ovsp;
    n.irq_stat = (q.irq_stat & ~irq_clr) | ev;
    n.irq      = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      q             <= '0;
      q.awready     <= 1'b1;
      q.wready      <= 1'b1;
      q.arready     <= 1'b1;
      q.mode        <= drs_pkg::drs_mode_t'(drs_pkg::MODE_RESET);
      q.sel         <= drs_pkg::SEL_RESET;
      q.limit       <= drs_pkg::LIMIT_RESET;
      q.fault_relay <= 1'b1;
      q.ovsp        <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  assign o_awready      = q.awready;
  assign o_wready       = q.wready;
  assign o_bvalid       = q.bvalid;
  assign o_bresp        = q.bresp;
  assign o_arready      = q.arready;
  assign o_rvalid       = q.rvalid;
  assign o_rdata        = q.rdata;
  assign o_rresp        = q.rresp;
  assign o_relay        = q.relay;
  assign o_lock_msg     = q.locked;
  assign o_evac_restart = q.evac_restart;
  assign o_irq          = q.irq;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_sto_blocked: assert property (q.sel[3:0] == drs_pkg::FN_STO_BLK |=>
    o_relay[0] == $past(i_sto_blocked)) else $error("Blocked indicator wrong.");
  chk_sto_clear: assert property (q.sel[7:4] == drs_pkg::FN_STO_CLR |=>
    o_relay[1] != $past(i_sto_blocked)) else $error("Clear indicator wrong.");
  chk_brake_info: assert property ((q.sel[11:8] == drs_pkg::FN_BRAKE) &&
    (&i_brake_open) && i_travel_active |=> o_relay[2]) else $error("Brake info wrong.");
  chk_fb_enable: assert property ((q.sel[15:12] == drs_pkg::FN_FB_EN) &&
    !(i_ctrl_enable && i_speed_sel && i_dir_sel) |=> !o_relay[3])
    else $error("Feedback enable without all conditions.");
  chk_overspeed_open: assert property (i_cabin_speed > q.limit |=> !q.ovsp)
    else $error("Overspeed brake did not open.");
  chk_overspeed_close: assert property (i_cabin_speed < q.limit |=> q.ovsp)
    else $error("Overspeed brake did not close.");
  chk_motor_short: assert property (q.sel[7:4] == drs_pkg::FN_MSHORT |=>
    o_relay[1] == $past(i_motor_short_req)) else $error("Short contactor wrong.");
  chk_evac_restart: assert property ((q.evac == EV_DISC) && i_battery_evac_active &&
    i_standstill |=> o_evac_restart ##1 !o_evac_restart) else $error("Evac restart wrong.");
  chk_regen_info: assert property (q.sel[11:8] == drs_pkg::FN_REGEN |=>
    o_relay[2] == $past(i_regen)) else $error("Regeneration indicator wrong.");
  chk_ready_locked: assert property ((q.sel[15:12] == drs_pkg::FN_READY) && q.locked
    |=> !o_relay[3]) else $error("Ready while locked.");
  chk_fix_drop: assert property ((q.mode == drs_pkg::MODE_FIX_2S) && i_fault &&
    !$rose(q.mode == drs_pkg::MODE_FIX_2S) |=> (!q.fault_relay && !q.locked) [*8])
    else $error("Timed dropout too short.");
  chk_lock_one: assert property ((q.mode == drs_pkg::MODE_LOCK_1) && i_fault &&
    !q.locked && !i_ack_key |=> q.locked && !q.fault_relay) else $error("No lock.");
  chk_cnt_clear: assert property ((q.mode != drs_pkg::MODE_FIX_2S) && i_travel_ok &&
    !i_fault && !q.locked |=> q.fault_cnt == 2'h0) else $error("Counter not cleared.");
  chk_unlock_ack: assert property (q.locked && i_ack_key &&
    (q.mode != drs_pkg::MODE_FIX_2S) |=> !o_lock_msg && q.fault_relay)
    else $error("Acknowledge did not unlock.");
  chk_cnt_step: assert property ((q.mode != drs_pkg::MODE_FIX_2S) && i_fault &&
    !q.locked |=> q.fault_cnt == 2'($past(q.fault_cnt) + 2'h1)) else $error("Count step.");

  cov_lock: cover property ($rose(q.locked));
  cov_evac: cover property (o_evac_restart);
  cov_drop: cover property ($rose(q.fault_relay));
  cov_irq: cover property ($rose(o_irq));

endmodule

// *** drs_ctrl_model.sv ***
// Purpose: Mains contactor and line supply facing the evacuation outputs.
// Assumes: Line voltage drops once the disconnect output closes.
// Notes:   Mains returns DELAY cycles after the drive asks to restart.
module drs_ctrl_model #(
  parameter int DELAY = 4
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_disconnect,
  input  wire logic i_restart,
  output logic      o_line_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_line_ok <= 1'b1;
      cnt <= 0;
    end
    else if (i_restart)
      cnt <= DELAY;
    else if (cnt == 1)
    begin
      o_line_ok <= 1'b1;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
    else if (i_disconnect)
      o_line_ok <= 1'b0;
  end
endmodule

// *** tb_top.sv ***
// Purpose: Self-checking bench of the status relay and fault lock block.
// Assumes: The drop time is shortened to 16 cycles.
// Notes:   Tests are sequences of register and pin accesses.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DROP = 16;
  logic        i_clk = 0;
  logic        i_reset = 1;
  logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, rdat;
  logic [1:0]  rs, br, rr;
  logic        sto = 0, trav = 0, cen = 0, spd = 0, dir = 0, msr = 0, evac = 0;
  logic        still = 0, regen = 0, rdy = 0, flt = 0, tok = 0, ack = 0, line_ok;
  logic [3:0]  brk = 0, rel;
  logic [15:0] cab = 0;
  logic        awr, wr, bv, arr, rv, lock, rst_req, irq;
  int          num_errors = 0, n_checks = 0, thr;
  drs_status_relays #(.DROP_CYCLES(DROP)) drs_status_relays_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
    .i_wvalid(wv), .o_wready(wr), .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv),
    .i_bready(bry), .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
    .o_rvalid(rv), .i_rready(rry), .o_rdata(rdat), .o_rresp(rr), .i_sto_blocked(sto),
    .i_brake_open(brk), .i_travel_active(trav), .i_ctrl_enable(cen), .i_speed_sel(spd),
    .i_dir_sel(dir), .i_cabin_speed(cab), .i_motor_short_req(msr),
    .i_battery_evac_active(evac), .i_standstill(still), .i_line_ok(line_ok),
    .i_regen(regen), .i_ready_cond(rdy), .i_fault(flt), .i_travel_ok(tok),
    .i_ack_key(ack), .o_relay(rel), .o_lock_msg(lock), .o_evac_restart(rst_req),
    .o_irq(irq));
  drs_ctrl_model #(.DELAY(4)) drs_ctrl_model_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_disconnect(rel[0]), .i_restart(rst_req), .o_line_ok(line_ok));
  always #50 i_clk = ~i_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge i_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge i_clk);
      ah = awv && awr === 1'b1;
      wh = wv && wr === 1'b1;
      bh = bv === 1'b1;
      rs = br;
      @(posedge i_clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      if (bh)
      begin
        bry <= 1'b0;
        return;
      end
    end
    num_errors++;
    tally_and_finish;
  endtask
  task automatic rd32(input logic [7:0] a);
    logic ah, rh;
    @(posedge i_clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge i_clk);
      ah = arv && arr === 1'b1;
      rh = rv === 1'b1;
      rd = rdat;
      rs = rr;
      @(posedge i_clk);
      if (ah) arv <= 1'b0;
      if (rh)
      begin
        rry <= 1'b0;
        return;
      end
    end
    num_errors++;
    tally_and_finish;
  endtask
  task automatic fault;
    flt <= 1'b1;
    tick(1);
    flt <= 1'b0;
    tick(3);
  endtask
  initial
  begin
    tick(8);
    i_reset <= 1'b0;
    rd32(8'h04);
    check(rd, 32'h719A);
    rd32(8'h08);
    check(rd, 32'h0100);
    rd32(8'h18);
    check(rs, 32'h2);
    wr32(8'h18, 32'h1);
    check(rs, 32'h2);
    $display("test registers done");
    wr32(8'h04, 32'h4321);
    tick(3);
    check(rel, 32'h2);
    sto <= 1'b1;
    brk <= 4'hF;
    trav <= 1'b1;
    cen <= 1'b1;
    spd <= 1'b1;
    dir <= 1'b1;
    tick(3);
    check(rel, 32'hD);
    cen <= 1'b0;
    brk <= 4'h7;
    tick(3);
    check(rel, 32'h1);
    wr32(8'h04, 32'h9865);
    msr <= 1'b1;
    rdy <= 1'b1;
    regen <= 1'b1;
    tick(3);
    check(rel, 32'hF);
    regen <= 1'b0;
    cab <= 16'h0101;
    tick(3);
    check(rel, 32'hA);
    cab <= 16'h0100;
    tick(3);
    check(rel, 32'hA);
    cab <= 16'h00FF;
    msr <= 1'b0;
    tick(3);
    check(rel, 32'h9);
    $display("test relay functions done");
    wr32(8'h04, 32'h000A);
    fault;
    check(rel, 32'h0);
    check(irq, 32'h0);
    tick(DROP - 4);
    check(rel, 32'h0);
    tick(6);
    check(rel, 32'h1);
    wr32(8'h14, 32'h1);
    tick(2);
    check(irq, 32'h1);
    wr32(8'h10, 32'h1);
    tick(2);
    check(irq, 32'h0);
    $display("test timed dropout done");
    wr32(8'h04, 32'h900A);
    for (int m = 1; m < 4; m++)
    begin
      wr32(8'h00, 32'(m));
      thr = 4 - m;
      repeat (thr - 1) fault;
      rd32(8'h0C);
      check(rd[2:1], 32'(thr - 1));
      check(lock, 32'h0);
      fault;
      check(lock, 32'h1);
      check(rel, 32'h0);
      ack <= 1'b1;
      tick(1);
      ack <= 1'b0;
      tick(3);
      check(lock, 32'h0);
      check(rel, 32'h9);
    end
    wr32(8'h00, 32'h2);
    fault;
    tok <= 1'b1;
    tick(1);
    tok <= 1'b0;
    fault;
    check(lock, 32'h0);
    $display("test lock modes done");
    wr32(8'h04, 32'h7);
    evac <= 1'b1;
    tick(3);
    check(rel, 32'h1);
    still <= 1'b1;
    for (thr = 0; thr < 20 && rst_req !== 1'b1; thr++) tick(1);
    check(thr < 20, 32'h1);
    evac <= 1'b0;
    tick(1);
    check(rel, 32'h1);
    for (thr = 0; thr < 20 && rel[0] !== 1'b0; thr++) tick(1);
    check(rel, 32'h0);
    $display("test evacuation done");
    tally_and_finish;
  end
endmodule
